// file: hdl/dpc_defines.vh
// Constants for the parameter channel interpreter
`ifndef DPC_DEFINES_VH
`define DPC_DEFINES_VH
// =====================================
// Identifier and index word fields
`define DPC_CMD_MSB 15
`define DPC_CMD_LSB 12
`define DPC_NUM_MSB 11
`define DPC_NUM_LSB 0
`define DPC_IDX_HI_MSB 15
`define DPC_IDX_HI_LSB 8
`define DPC_IDX_LO_MSB 7
`define DPC_IDX_LO_LSB 0
`define DPC_TXT_RD_HI 8'h04
// =====================================
// Command codes
`define DPC_CMD_NONE 4'h0
`define DPC_CMD_READ 4'h1
`define DPC_CMD_WR_W 4'h2
`define DPC_CMD_WR_D 4'h3
`define DPC_CMD_WR_DNV 4'hd
`define DPC_CMD_WR_WNV 4'he
`define DPC_CMD_TEXT 4'hf
// =====================================
// Response codes
`define DPC_RSP_NONE 4'h0
`define DPC_RSP_WORD 4'h1
`define DPC_RSP_DWORD 4'h2
`define DPC_RSP_FAIL 4'h7
`define DPC_RSP_TEXT 4'hf
// =====================================
// Fault codes
`define DPC_F_NUM 8'h00
`define DPC_F_LIMIT 8'h02
`define DPC_F_SUBIDX 8'h03
`define DPC_F_NOARR 8'h04
`define DPC_F_TYPE 8'h05
`define DPC_F_DESC 8'h09
`define DPC_F_NOWR 8'h0b
`define DPC_F_NOTXT 8'h0f
`define DPC_F_RUN 8'h11
`define DPC_F_OTHER 8'h12
`define DPC_F_NOBUS 8'h82
`define DPC_F_FACT 8'h83
`define DPC_F_PANEL 8'h84
`define DPC_F_VIEWER 8'hfc
`define DPC_F_UNSUP 8'hfd
`define DPC_F_ATTR 8'hfe
`define DPC_F_NONE 8'hff
// =====================================
// Data types
`define DPC_DT_NONE 4'h0
`define DPC_DT_I16 4'h3
`define DPC_DT_I32 4'h4
`define DPC_DT_U8 4'h5
`define DPC_DT_U16 4'h6
`define DPC_DT_U32 4'h7
`define DPC_DT_TEXT 4'h9
`define DPC_DT_VIEWER 4'hf
// =====================================
// Attribute word layout
`define DPC_ATTR_W 22
`define DPC_A_TYPE_MSB 3
`define DPC_A_TYPE_LSB 0
`define DPC_A_WR 4
`define DPC_A_ARR 5
`define DPC_A_BUS 6
`define DPC_A_RUNLOCK 7
`define DPC_A_CONV_MSB 15
`define DPC_A_CONV_LSB 8
`define DPC_A_LEN_MSB 21
`define DPC_A_LEN_LSB 16
// =====================================
// Conversion indices and factors
`define DPC_CONV_HOUR 8'h4a
`define DPC_CONV_P2 8'h02
`define DPC_CONV_P1 8'h01
`define DPC_CONV_P0 8'h00
`define DPC_CONV_M1 8'hff
`define DPC_CONV_M2 8'hfe
`define DPC_CONV_M3 8'hfd
`define DPC_CONV_M4 8'hfc
`define DPC_CONV_M5 8'hfb
`define DPC_FAC_HOUR 12'he10
`define DPC_FAC_P2 12'h064
`define DPC_FAC_P1 12'h00a
`define DPC_FAC_ONE 12'h001
// =====================================
// Telegram lengths
`define DPC_LEN_PARAM 8'h0e
`define DPC_LEN_TXT_FIX 8'h0a
`endif

// file: hdl/dpc_param_mem.v
// Parameter value and attribute store with registered read
module dpc_param_mem #(
	parameter AW = 10,
	parameter TW = 22
) (
	input wire clk_i,
	input wire we_i,
	input wire [AW-1:0] waddr_i,
	input wire [31:0] wdata_i,
	input wire wattr_en_i,
	input wire [TW-1:0] wattr_i,
	input wire [AW-1:0] vaddr_i,
	input wire [AW-1:0] aaddr_i,
	output reg [31:0] vdata_o,
	output reg [TW-1:0] adata_o
);
	reg [31:0] val_mem [0:(1<<AW)-1];
	reg [TW-1:0] attr_mem [0:(1<<AW)-1];
	// =====================================
	// Write and registered read
	always @(posedge clk_i)
	begin
		if (we_i)
			val_mem[waddr_i] <= wdata_i;
		if (wattr_en_i)
			attr_mem[waddr_i] <= wattr_i;
		vdata_o <= val_mem[vaddr_i];
		adata_o <= attr_mem[aaddr_i];
	end
endmodule

// file: hdl/dpc_conv_scale.v
// Conversion index scaler for transferred whole numbers
`include "dpc_defines.vh"
module dpc_conv_scale (
	input wire clk_i,
	input wire rst_b_i,
	input wire load_i,
	input wire [31:0] value_i,
	input wire value_signed_i,
	input wire [7:0] conv_i,
	output reg conv_ok_o,
	output reg [44:0] mant_o,
	output reg [2:0] exp_o
);
	reg [11:0] factor;
	reg [2:0] dexp;
	wire signed [44:0] prod;
	// =====================================
	// Factor lookup
	always @*
	begin
		factor = `DPC_FAC_ONE;
		dexp = 3'h0;
		conv_ok_o = 1'b1;
		case (conv_i)
			`DPC_CONV_HOUR: factor = `DPC_FAC_HOUR;
			`DPC_CONV_P2: factor = `DPC_FAC_P2;
			`DPC_CONV_P1: factor = `DPC_FAC_P1;
			`DPC_CONV_P0: factor = `DPC_FAC_ONE;
			`DPC_CONV_M1: dexp = 3'h1;
			`DPC_CONV_M2: dexp = 3'h2;
			`DPC_CONV_M3: dexp = 3'h3;
			`DPC_CONV_M4: dexp = 3'h4;
			`DPC_CONV_M5: dexp = 3'h5;
			default: conv_ok_o = 1'b0;
		endcase
	end
	wire [32:0] value_ext = {value_signed_i & value_i[31], value_i};
	assign prod = $signed(value_ext) * $signed({1'b0, factor});
	always @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			mant_o <= 45'h0;
			exp_o <= 3'h0;
		end
		else if (load_i)
		begin
			mant_o <= prod;
			exp_o <= dexp;
		end
	end
endmodule

// file: hdl/dpc_param_channel.v
// Parameter and process word interpreter of the drive serial link
// Operation
// - Failed request reports fault 0,2,3,4,5,9,11,15,17 or 18 by cause.
// - Extended faults 130,131,132,252,253,254, 255 means none; 6,7 unused.
// - Identifier word bits 11..0 select the parameter number.
// - Index has low and high byte; only low byte indexes arrays.
// - Value field is two words, meaning set by the command code.
// - Read returns the parameter's present value in the value field.
// - Text string parameters are read only over the link.
// - Text answer length is fixed part plus text, in length byte.
// - For text commands the index decides read versus write.
// - Data types 3,4,5,6,7 and 9 supported; unsigned carry no sign.
// - Values travel as whole numbers only.
// - Value scales by conversion factor: 74,2,1,0,-1..-5.
// - Process words: control then reference in, status then frequency out.
// - Command or response code sits in identifier bits 15..12.
// - Decode none, read, word/dword volatile and non-volatile writes, text.
// - Answer word, double word, text or none response codes.
// - Unexecutable command answers code 0111 with a fault code.
`include "dpc_defines.vh"
module dpc_param_channel #(
	parameter AW = 10
) (
	input wire clk_i,
	input wire rst_b_i,
	input wire req_valid_i,
	output wire req_ready_o,
	input wire [15:0] req_ident_i,
	input wire [15:0] req_index_i,
	input wire [31:0] req_value_i,
	input wire [15:0] req_ctrl_word_i,
	input wire [15:0] req_reference_i,
	output reg rsp_valid_o,
	output reg [15:0] rsp_ident_o,
	output reg [15:0] rsp_index_o,
	output reg [31:0] rsp_value_o,
	output reg [15:0] rsp_status_word_o,
	output reg [15:0] rsp_out_freq_o,
	output reg [7:0] rsp_length_o,
	output reg txt_valid_o,
	output reg [7:0] txt_byte_o,
	output reg txt_last_o,
	input wire txt_ready_i,
	output reg [11:0] txt_rd_num_o,
	output reg [5:0] txt_rd_pos_o,
	input wire [7:0] txt_char_i,
	input wire [15:0] status_word_i,
	input wire [15:0] out_freq_i,
	input wire drive_running_i,
	input wire factory_setup_i,
	input wire panel_edit_i,
	input wire cfg_we_i,
	input wire [AW-1:0] cfg_addr_i,
	input wire [31:0] cfg_value_i,
	input wire [`DPC_ATTR_W-1:0] cfg_attr_i,
	output reg [15:0] ctrl_word_o,
	output reg [15:0] reference_o,
	output reg proc_update_o,
	output reg nv_store_o,
	output reg [AW-1:0] nv_addr_o,
	output reg [7:0] fault_code_o,
	output wire [44:0] eng_mant_o,
	output wire [2:0] eng_exp_o
);
	localparam [2:0] ST_IDLE = 3'h0;
	localparam [2:0] ST_LOOK = 3'h1;
	localparam [2:0] ST_EXEC = 3'h2;
	localparam [2:0] ST_TFETCH = 3'h3;
	localparam [2:0] ST_TSEND = 3'h4;
	localparam [12:0] NUM_MAX = (13'h1 << AW) - 13'h1;

	reg [2:0] state_q, state_d;
	reg [15:0] ident_q;
	reg [15:0] index_q;
	reg [31:0] value_q;
	reg [5:0] tlen_q;
	reg [7:0] fault;
	reg [3:0] rsp_code;
	reg [31:0] rsp_val;
	reg bus_we;
	reg scale_ld;
	reg text_go;
	reg limit_bad;
	wire [31:0] vdata;
	wire [`DPC_ATTR_W-1:0] adata;
	wire conv_ok;
	// =====================================
	// Field decode
	// command code field
	wire [3:0] cmd = ident_q[`DPC_CMD_MSB:`DPC_CMD_LSB];
	wire [11:0] param_number = ident_q[`DPC_NUM_MSB:`DPC_NUM_LSB];
	wire [7:0] idx_lo = index_q[`DPC_IDX_LO_MSB:`DPC_IDX_LO_LSB];
	wire [7:0] idx_hi = index_q[`DPC_IDX_HI_MSB:`DPC_IDX_HI_LSB];
	wire [3:0] dtype = adata[`DPC_A_TYPE_MSB:`DPC_A_TYPE_LSB];
	wire [7:0] conv = adata[`DPC_A_CONV_MSB:`DPC_A_CONV_LSB];
	wire [5:0] alen = adata[`DPC_A_LEN_MSB:`DPC_A_LEN_LSB];
	wire num_bad = ({1'b0, param_number} > NUM_MAX);
	wire [AW:0] vsum = {1'b0, param_number[AW-1:0]} + {{(AW-7){1'b0}}, idx_lo};
	wire is_read = (cmd == `DPC_CMD_READ);
	wire is_word = (cmd == `DPC_CMD_WR_W) || (cmd == `DPC_CMD_WR_WNV);
	wire is_nv = (cmd == `DPC_CMD_WR_DNV) || (cmd == `DPC_CMD_WR_WNV);
	wire is_write = is_word || is_nv || (cmd == `DPC_CMD_WR_D);
	wire is_text = (cmd == `DPC_CMD_TEXT);
	wire is_none = (cmd == `DPC_CMD_NONE);
	wire text_rd = is_text && (idx_hi == `DPC_TXT_RD_HI);
	wire type_ok = (dtype == `DPC_DT_I16) || (dtype == `DPC_DT_I32) || (dtype == `DPC_DT_U8) ||
		(dtype == `DPC_DT_U16) || (dtype == `DPC_DT_U32) || (dtype == `DPC_DT_TEXT);
	wire wide_type = (dtype == `DPC_DT_I32) || (dtype == `DPC_DT_U32);
	// word write takes low word, sign only for integer 16
	wire [31:0] wr_eff = !is_word ? value_q :
		(dtype == `DPC_DT_I16) ? {{16{value_q[15]}}, value_q[15:0]} : {16'h0, value_q[15:0]};

	assign req_ready_o = (state_q == ST_IDLE);
	// =====================================
	// Range check by type
	always @*
	begin
		case (dtype)
			`DPC_DT_U8: limit_bad = |wr_eff[31:8];
			`DPC_DT_U16: limit_bad = |wr_eff[31:16];
			`DPC_DT_I16: limit_bad = (wr_eff[31:16] != {16{wr_eff[15]}});
			default: limit_bad = 1'b0;
		endcase
	end
	// =====================================
	// Request evaluation
	always @*
	begin
		fault = `DPC_F_NONE;
		if (is_none)
			fault = `DPC_F_NONE;
		else if (!(is_read || is_write || is_text))
			fault = `DPC_F_UNSUP;
		else if (num_bad || dtype == `DPC_DT_NONE)
			fault = `DPC_F_NUM;
		else if (dtype == `DPC_DT_VIEWER)
			fault = `DPC_F_VIEWER;
		else if (!adata[`DPC_A_BUS])
			fault = `DPC_F_NOBUS;
		else if (!type_ok)
			fault = `DPC_F_DESC;
		else if (is_text && dtype != `DPC_DT_TEXT)
			fault = `DPC_F_NOTXT;
		else if (is_text && !text_rd)
			fault = `DPC_F_NOWR;
		else if (is_text && alen == 6'h0)
			fault = `DPC_F_NOTXT;
		else if (is_text)
			fault = `DPC_F_NONE;
		else if (!adata[`DPC_A_ARR] && idx_lo != 8'h0)
			fault = `DPC_F_NOARR;
		else if (adata[`DPC_A_ARR] && (idx_lo >= {2'h0, alen} || vsum[AW]))
			fault = `DPC_F_SUBIDX;
		else if (!conv_ok)
			fault = `DPC_F_ATTR;
		else if (is_write && dtype == `DPC_DT_TEXT)
			fault = `DPC_F_NOWR;
		else if (is_read && dtype == `DPC_DT_TEXT)
			fault = `DPC_F_TYPE;
		else if (is_write && !adata[`DPC_A_WR])
			fault = `DPC_F_NOWR;
		else if (is_write && factory_setup_i)
			fault = `DPC_F_FACT;
		else if (is_write && panel_edit_i)
			fault = `DPC_F_PANEL;
		else if (is_write && drive_running_i && adata[`DPC_A_RUNLOCK])
			fault = `DPC_F_RUN;
		else if (is_word && wide_type)
			fault = `DPC_F_TYPE;
		else if (is_write && limit_bad)
			fault = `DPC_F_LIMIT;
		else if (is_write && cfg_we_i)
			fault = `DPC_F_OTHER;
	end
	// =====================================
	// Response selection
	always @*
	begin
		rsp_code = `DPC_RSP_NONE;
		rsp_val = 32'h0;
		bus_we = 1'b0;
		scale_ld = 1'b0;
		text_go = 1'b0;
		if (is_none)
			rsp_code = `DPC_RSP_NONE;
		else if (fault != `DPC_F_NONE)
		begin
			rsp_code = `DPC_RSP_FAIL;
			rsp_val = {24'h0, fault};
		end
		else if (is_text)
		begin
			rsp_code = `DPC_RSP_TEXT;
			text_go = 1'b1;
		end
		else if (is_read)
		begin
			rsp_code = wide_type ? `DPC_RSP_DWORD : `DPC_RSP_WORD;
			rsp_val = vdata;
			scale_ld = 1'b1;
		end
		else
		begin
			rsp_code = is_word ? `DPC_RSP_WORD : `DPC_RSP_DWORD;
			rsp_val = wr_eff;
			bus_we = 1'b1;
			scale_ld = 1'b1;
		end
	end
	// =====================================
	// Sequencer
	always @*
	begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: if (req_valid_i) state_d = ST_LOOK;
			ST_LOOK: state_d = ST_EXEC;
			ST_EXEC: state_d = text_go ? ST_TFETCH : ST_IDLE;
			ST_TFETCH: state_d = ST_TSEND;
			ST_TSEND:
				if (txt_ready_i)
					state_d = txt_last_o ? ST_IDLE : ST_TFETCH;
			default: state_d = ST_IDLE;
		endcase
	end

	always @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			state_q <= ST_IDLE;
			ident_q <= 16'h0;
			index_q <= 16'h0;
			value_q <= 32'h0;
			tlen_q <= 6'h0;
			rsp_valid_o <= 1'b0;
			rsp_ident_o <= 16'h0;
			rsp_index_o <= 16'h0;
			rsp_value_o <= 32'h0;
			rsp_status_word_o <= 16'h0;
			rsp_out_freq_o <= 16'h0;
			rsp_length_o <= 8'h0;
			txt_valid_o <= 1'b0;
			txt_byte_o <= 8'h0;
			txt_last_o <= 1'b0;
			txt_rd_num_o <= 12'h0;
			txt_rd_pos_o <= 6'h0;
			ctrl_word_o <= 16'h0;
			reference_o <= 16'h0;
			proc_update_o <= 1'b0;
			nv_store_o <= 1'b0;
			nv_addr_o <= {AW{1'b0}};
			fault_code_o <= `DPC_F_NONE;
		end
		else
		begin
			state_q <= state_d;
			rsp_valid_o <= 1'b0;
			proc_update_o <= 1'b0;
			nv_store_o <= 1'b0;
			if (state_q == ST_IDLE && req_valid_i)
			begin
				ident_q <= req_ident_i;
				index_q <= req_index_i;
				value_q <= req_value_i;
				ctrl_word_o <= req_ctrl_word_i;
				reference_o <= req_reference_i;
				proc_update_o <= 1'b1;
			end
			if (state_q == ST_EXEC)
			begin
				rsp_valid_o <= 1'b1;
				rsp_ident_o <= {rsp_code, param_number};
				rsp_index_o <= index_q;
				rsp_value_o <= rsp_val;
				rsp_status_word_o <= status_word_i;
				rsp_out_freq_o <= out_freq_i;
				rsp_length_o <= text_go ? (`DPC_LEN_TXT_FIX + {2'h0, alen}) : `DPC_LEN_PARAM;
				fault_code_o <= fault;
				tlen_q <= alen;
				txt_rd_num_o <= param_number;
				txt_rd_pos_o <= 6'h0;
				nv_store_o <= bus_we && is_nv;
				nv_addr_o <= vsum[AW-1:0];
			end
			if (state_q == ST_TFETCH)
			begin
				txt_valid_o <= 1'b1;
				txt_byte_o <= txt_char_i;
				txt_last_o <= (txt_rd_pos_o == tlen_q - 6'h1);
			end
			if (state_q == ST_TSEND && txt_ready_i)
			begin
				txt_valid_o <= 1'b0;
				txt_last_o <= 1'b0;
				txt_rd_pos_o <= txt_rd_pos_o + 6'h1;
			end
		end
	end
	// =====================================
	// Parameter store and scaler
	dpc_param_mem #(
		.AW(AW),
		.TW(`DPC_ATTR_W)
	) u_mem (
		.clk_i(clk_i),
		.we_i(cfg_we_i || (state_q == ST_EXEC && bus_we)),
		.waddr_i(cfg_we_i ? cfg_addr_i : vsum[AW-1:0]),
		.wdata_i(cfg_we_i ? cfg_value_i : wr_eff),
		.wattr_en_i(cfg_we_i),
		.wattr_i(cfg_attr_i),
		.vaddr_i(vsum[AW-1:0]),
		.aaddr_i(param_number[AW-1:0]),
		.vdata_o(vdata),
		.adata_o(adata)
	);

	dpc_conv_scale u_scale (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.load_i(state_q == ST_EXEC && scale_ld),
		.value_i(is_write ? wr_eff : vdata),
		.value_signed_i((dtype == `DPC_DT_I16) || (dtype == `DPC_DT_I32)),
		.conv_i(conv),
		.conv_ok_o(conv_ok),
		.mant_o(eng_mant_o),
		.exp_o(eng_exp_o)
	);
endmodule

// file: tb/dpc_param_channel_asserts.sv
// Port checker for the parameter channel interpreter
module dpc_param_channel_asserts #(
	parameter AW = 10
) (
	input wire clk_i,
	input wire rst_b_i,
	input wire req_valid_i,
	input wire req_ready_o,
	input wire [15:0] req_ident_i,
	input wire [15:0] req_ctrl_word_i,
	input wire [15:0] req_reference_i,
	input wire rsp_valid_o,
	input wire [15:0] rsp_ident_o,
	input wire [31:0] rsp_value_o,
	input wire [7:0] rsp_length_o,
	input wire [15:0] rsp_status_word_o,
	input wire [15:0] status_word_i,
	input wire [7:0] fault_code_o,
	input wire [15:0] ctrl_word_o,
	input wire [15:0] reference_o,
	input wire proc_update_o,
	input wire txt_valid_o,
	input wire [7:0] txt_byte_o,
	input wire txt_ready_i
);
	timeunit 1ns;
	timeprecision 1ps;
	// ==========================
	// Request capture
	reg [3:0] cmd_q;
	reg [11:0] num_q;
	wire take = req_valid_i && req_ready_o;
	wire unsup = !(cmd_q inside {4'h0, 4'h1, 4'h2, 4'h3, 4'hd, 4'he, 4'hf});
	wire [3:0] code = rsp_ident_o[15:12];
	always @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			cmd_q <= 4'h0;
			num_q <= 12'h000;
		end
		else if (take)
		begin
			cmd_q <= req_ident_i[15:12];
			num_q <= req_ident_i[11:0];
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	// ==========================
	// Assertions
	chk_rsp_latency: assert property (take |-> ##[1:3] rsp_valid_o)
		else $error("no response in time");
	chk_ready_drop: assert property (take |=> !req_ready_o)
		else $error("ready stayed high after take");
	chk_rsp_pulse: assert property (rsp_valid_o |=> !rsp_valid_o)
		else $error("response valid too long");
	chk_proc_load: assert property (take |=> proc_update_o && ctrl_word_o == $past(req_ctrl_word_i)
		&& reference_o == $past(req_reference_i)) else $error("process words not loaded");
	chk_num_echo: assert property (rsp_valid_o |-> rsp_ident_o[11:0] == num_q)
		else $error("parameter number not echoed");
	chk_fail_word: assert property (rsp_valid_o && code == 4'h7 |->
		rsp_value_o == {24'h000000, fault_code_o} && fault_code_o != 8'hff) else $error("bad failure value");
	chk_ok_nofault: assert property (rsp_valid_o && (code == 4'h1 || code == 4'h2) |-> fault_code_o == 8'hff)
		else $error("fault on success");
	chk_unsup_cmd: assert property (rsp_valid_o && unsup |-> code == 4'h7 && rsp_value_o[7:0] == 8'hfd)
		else $error("unknown command not refused");
	chk_len_fixed: assert property (rsp_valid_o && code != 4'hf |-> rsp_length_o == 8'h0e)
		else $error("bad fixed length");
	chk_status_copy: assert property (rsp_valid_o && $stable(status_word_i) |-> rsp_status_word_o == status_word_i)
		else $error("status word not returned");
	chk_txt_hold: assert property (txt_valid_o && !txt_ready_i |=> txt_valid_o && $stable(txt_byte_o))
		else $error("text byte dropped");
endmodule

// file: tb/dpc_txt_partner.sv
// Text store and stalling byte consumer
module dpc_txt_partner (
	input wire clk_i,
	input wire rst_b_i,
	input wire [11:0] txt_rd_num_i,
	input wire [5:0] txt_rd_pos_i,
	input wire txt_valid_i,
	output wire [7:0] txt_char_o,
	output reg txt_ready_o
);
	timeunit 1ns;
	timeprecision 1ps;
	assign txt_char_o = (8'h30 + {2'h0, txt_rd_pos_i}) ^ txt_rd_num_i[7:0];
	// Accept every other cycle
	always @(posedge clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
			txt_ready_o <= 1'b0;
		else if (txt_valid_i)
			txt_ready_o <= ~txt_ready_o;
	end
endmodule

// file: tb/tb_drive_param_channel.sv
// Testbench of the parameter channel interpreter
module tb_drive_param_channel;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 0, rst_b_i = 0, req_valid_i = 0, cfg_we_i = 0;
	logic drive_running_i = 0, factory_setup_i = 0, panel_edit_i = 0;
	logic [15:0] req_ident_i = 0, req_index_i = 0, req_ctrl_word_i = 0, req_reference_i = 0;
	logic [15:0] status_word_i = 16'h0237, out_freq_i = 16'h01f4;
	logic [31:0] req_value_i = 0, cfg_value_i = 0;
	logic [9:0] cfg_addr_i = 0;
	logic [21:0] cfg_attr_i = 0;
	wire req_ready_o, rsp_valid_o, txt_valid_o, txt_last_o, txt_ready_i, proc_update_o, nv_store_o;
	wire [15:0] rsp_ident_o, rsp_index_o, rsp_status_word_o, rsp_out_freq_o, ctrl_word_o, reference_o;
	wire [31:0] rsp_value_o;
	wire [7:0] rsp_length_o, txt_byte_o, txt_char_i, fault_code_o;
	wire [11:0] txt_rd_num_o;
	wire [5:0] txt_rd_pos_o;
	wire [9:0] nv_addr_o;
	wire [44:0] eng_mant_o;
	wire [2:0] eng_exp_o;
	int err_total = 0;
	int comparisons = 0;
	dpc_param_channel #(.AW(10)) i_dut (.*);
	dpc_txt_partner i_partner (.clk_i(clk_i), .rst_b_i(rst_b_i), .txt_rd_num_i(txt_rd_num_o),
		.txt_rd_pos_i(txt_rd_pos_o), .txt_valid_i(txt_valid_o), .txt_char_o(txt_char_i), .txt_ready_o(txt_ready_i));
	always #20 clk_i = ~clk_i;
	// ==========================
	// Shared tasks
	task automatic check(input string nm, input logic [44:0] seen, input logic [44:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			err_total++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic cfg(input [9:0] a, input [31:0] v, input [5:0] len, input [7:0] conv, input [3:0] fl, input [3:0] ty);
		@(negedge clk_i);
		{cfg_we_i, cfg_addr_i, cfg_value_i, cfg_attr_i} = {1'b1, a, v, len, conv, fl, ty};
		@(negedge clk_i);
		cfg_we_i = 0;
	endtask
	task automatic req(input [15:0] id, input [15:0] ix, input [31:0] v, input [2:0] fl);
		int n;
		n = 0;
		@(negedge clk_i);
		while (req_ready_o !== 1'b1 && n < 50)
		begin
			@(negedge clk_i);
			n++;
		end
		{drive_running_i, factory_setup_i, panel_edit_i} = fl;
		{req_ident_i, req_index_i, req_value_i, req_valid_i} = {id, ix, v, 1'b1};
		{req_ctrl_word_i, req_reference_i} = {id ^ 16'h5a5a, ~id};
		@(negedge clk_i);
		req_valid_i = 0;
		n = 0;
		while (rsp_valid_o !== 1'b1 && n < 8)
		begin
			@(posedge clk_i);
			#1;
			n++;
		end
		check("response", {44'h0, rsp_valid_o}, 45'h1);
	endtask
	task automatic stop_test;
		$display("err_total=%0d comparisons=%0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ==========================
	// Scenarios
	task automatic t_rw;
		logic [51:0] w [4] = '{52'he006_000003e8_1, 52'h2006_00000007_1, 52'h3005_00010002_2, 52'hd005_000003e8_2};
		for (int i = 0; i < 4; i++)
		begin
			req(w[i][51:36], 16'h0, w[i][35:4], 3'h0);
			check("write code", rsp_ident_o[15:12], w[i][3:0]);
			check("nv store", nv_store_o, w[i][51]);
			req({4'h1, w[i][47:36]}, 16'h0, 32'h0, 3'h0);
			check("readback", rsp_value_o, w[i][35:4]);
		end
		check("nv address", nv_addr_o, 10'h005);
		check("read code", rsp_ident_o[15:12], 4'h2);
		check("mantissa", eng_mant_o, 45'd1000);
		check("exponent", eng_exp_o, 3'h2);
		check("ctrl word", ctrl_word_o, 16'h4a5f);
		check("out freq", rsp_out_freq_o, out_freq_i);
		req(16'h1006, 16'h0, 32'h0, 3'h0);
		check("hour mantissa", eng_mant_o, 45'd25200);
		check("hour exponent", eng_exp_o, 3'h0);
		req(16'h3006, 16'h0, 32'h00010000, 3'h0);
		check("limit code", rsp_ident_o[15:12], 4'h7);
		check("limit fault", rsp_value_o, 32'h2);
		req(16'h3005, 16'h0, 32'h80000000, 3'h0);
		check("unsigned mantissa", eng_mant_o, 45'h80000000);
	endtask
	task automatic t_faults;
		logic [47:0] t [15] = '{48'h000500000000, 48'h4005000007fd, 48'hc005000007fd, 48'h180000000700,
			48'h100800000782, 48'h20070000070b, 48'hf0050400070f, 48'hf0090000070b, 48'h20090000070b,
			48'h100500010704, 48'h101403040703, 48'h200a00004711, 48'h200600002783, 48'h200600001784,
			48'h200500000705};
		for (int i = 0; i < 15; i++)
		begin
			req(t[i][47:32], t[i][31:16], 32'h0, t[i][14:12]);
			check("fail code", rsp_ident_o[15:12], t[i][11:8]);
			check("fail value", rsp_value_o, {24'h0, t[i][7:0]});
			check("index echo", rsp_index_o, t[i][31:16]);
		end
	endtask
	task automatic t_text;
		int n;
		req(16'hf009, 16'h0400, 32'h0, 3'h0);
		check("text code", rsp_ident_o[15:12], 4'hf);
		check("text length", rsp_length_o, 8'h0d);
		for (int i = 0; i < 3; i++)
		begin
			n = 0;
			@(negedge clk_i);
			while (!(txt_valid_o === 1'b1 && txt_ready_i === 1'b1) && n < 20)
			begin
				@(negedge clk_i);
				n++;
			end
			check("text byte", txt_byte_o, (8'h30 + i) ^ 8'h09);
			check("text last", txt_last_o, i == 2);
		end
	endtask
	// ==========================
	// Main sequence
	initial
	begin
		repeat (2) @(posedge clk_i);
		@(negedge clk_i);
		rst_b_i = 1;
		check("idle fault", fault_code_o, 8'hff);
		check("idle ready", req_ready_o, 1'b1);
		cfg(10'h005, 32'h3e8, 6'h0, 8'hfe, 4'h5, 4'h7);
		cfg(10'h006, 32'h0, 6'h0, 8'h4a, 4'h5, 4'h6);
		cfg(10'h007, 32'h0, 6'h0, 8'h00, 4'h4, 4'h6);
		cfg(10'h008, 32'h0, 6'h0, 8'h00, 4'h1, 4'h6);
		cfg(10'h009, 32'h0, 6'h3, 8'h00, 4'h4, 4'h9);
		cfg(10'h00a, 32'h0, 6'h0, 8'h00, 4'hd, 4'h6);
		cfg(10'h014, 32'h0, 6'h4, 8'h00, 4'h7, 4'h6);
		t_rw();
		t_faults();
		t_text();
		stop_test();
	end
	initial
	begin
		#200000;
		err_total++;
		stop_test();
	end
endmodule
bind dpc_param_channel dpc_param_channel_asserts #(.AW(AW)) i_chk (.*);
